//--- include/rtzf_pkg.sv
// Purpose: Shared constants for the route indicator and management frame block
// Assumes: Byte-wide serial frames, one byte per accepted handshake
// Notes: Offsets are frame byte positions counted from the start delimiter
package rtzf_pkg;
	localparam logic [7:0] RTZF_START_DELIM = 8'h7E;
	localparam logic [7:0] RTZF_TYPE_ROUTE_IND = 8'hA3;
	localparam logic [7:0] RTZF_TYPE_EXPLICIT = 8'h11;
	localparam logic [15:0] RTZF_IND_LENGTH = 16'h000C;
	localparam logic [7:0] RTZF_RESERVED_VAL = 8'h00;
	localparam logic [7:0] RTZF_CHK_BASE = 8'hFF;
	localparam logic [7:0] RTZF_ZERO_BYTE = 8'h00;
	localparam logic [15:0] RTZF_ZDO_PROFILE = 16'h0000;
	// Frame byte positions
	localparam logic [4:0] RTZF_OFS_TYPE = 5'h03;
	localparam logic [4:0] RTZF_OFS_SRC64_FIRST = 5'h04;
	localparam logic [4:0] RTZF_OFS_SRC64_LAST = 5'h0B;
	localparam logic [4:0] RTZF_OFS_SRC16_MSB = 5'h0C;
	localparam logic [4:0] RTZF_OFS_SRC16_LSB = 5'h0D;
	localparam logic [4:0] RTZF_OFS_RESERVED = 5'h0E;
	localparam logic [4:0] RTZF_OFS_CHECKSUM = 5'h0F;
	localparam logic [4:0] RTZF_OFS_FRAME_ID = 5'h04;
	localparam logic [4:0] RTZF_OFS_RADIUS = 5'h15;
	// Default hop limit used when the host asks for zero
	localparam logic [7:0] RTZF_NET_MAX_HOPS = 8'h1E;
endpackage

//--- core/rtzf_route_ind.sv
// Purpose: Emits the many-to-one route request indicator frame on the serial byte stream
// Assumes: Byte stream with valid/ready; one request pulse per received broadcast
// Notes: A two-entry skid buffer sits before the output so a receiver stall loses no byte
`timescale 1ns/1ps
`default_nettype none
module rtzf_route_ind
	import rtzf_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// Indicator request from the network side
	input wire logic IND_REQ,
	input wire logic [63:0] IND_SRC64,
	input wire logic [15:0] IND_SRC16,
	output logic IND_BUSY,
	// Transmit options from the host frame parser
	input wire logic TX_REQ,
	input wire logic [7:0] TX_FRAME_ID,
	input wire logic [7:0] TX_RADIUS,
	output logic TX_STATUS_WANTED,
	output logic [7:0] TX_HOPS,
	// Serial byte stream toward the host
	output logic TX_VALID,
	output logic [7:0] TX_DATA,
	input wire logic TX_READY
);
	// Frame layout as it leaves the buffer, one byte per accepted handshake:
	//   position 0       start delimiter
	//   positions 1-2    length, high byte first
	//   position 3       frame type
	//   positions 4-11   sender long address, high byte first
	//   positions 12-13  initiator network address, high byte first
	//   position 14      reserved, always zero
	//   position 15      checksum over positions 3 to 14
	// The long address is shifted left one byte per push, so only its top byte
	// is ever read; this avoids a wide eight-way byte multiplexer.
	//
	// Buffer behaviour:
	//   The two-entry buffer accepts a push whenever it is not full.
	//   A pop and a push may fall in one cycle; the pop is applied first, so the
	//   pushed byte lands behind whatever remains.
	//   The framer never waits on the receiver directly, only on a full buffer,
	//   which keeps the ready path from the host out of the byte decode.
	//
	// Request handling:
	//   A new indicator request is taken only in the idle state.
	//   Busy stays high until the last byte has left the buffer, so a request
	//   that arrives mid-frame is dropped rather than queued.
	//   There is no queue for requests; the network side must retry or hold.
	//
	// Option decode:
	//   Status-wanted flag and hop limit of the latest host frame are held
	//   until the next host frame arrives; they do not depend on the framer.
	//
	// Valid is kept as its own flop so the output does not pass through a
	// compare after the counter.
	typedef enum logic [2:0] {
		RTZF_IDLE = 3'b001,
		RTZF_SEND = 3'b010,
		RTZF_DONE = 3'b100
	} rtzf_state_t;

	typedef struct packed {
		rtzf_state_t state;
		logic [4:0] idx;
		logic [63:0] src64;
		logic [15:0] src16;
		logic [7:0] sum;
		logic [1:0][7:0] buf_data;
		logic [1:0] cnt;
		logic out_valid;
		logic busy;
		logic status_wanted;
		logic [7:0] hops;
	} rtzf_regs_t;

	rtzf_regs_t r;
	rtzf_regs_t next_r;
	logic [7:0] cur_byte;
	logic push;
	logic pop;
	logic buf_ready;

	// Byte for the current frame position
	always_comb
	begin
		cur_byte = RTZF_ZERO_BYTE;
		if (r.idx == 5'h00)
			cur_byte = RTZF_START_DELIM;
		else if (r.idx == 5'h01)
			cur_byte = RTZF_IND_LENGTH[15:8];
		else if (r.idx == 5'h02)
			cur_byte = RTZF_IND_LENGTH[7:0];
		else if (r.idx == RTZF_OFS_TYPE)
			cur_byte = RTZF_TYPE_ROUTE_IND;
		else if (r.idx >= RTZF_OFS_SRC64_FIRST && r.idx <= RTZF_OFS_SRC64_LAST)
			cur_byte = r.src64[63:56];
		else if (r.idx == RTZF_OFS_SRC16_MSB)
			cur_byte = r.src16[15:8];
		else if (r.idx == RTZF_OFS_SRC16_LSB)
			cur_byte = r.src16[7:0];
		else if (r.idx == RTZF_OFS_RESERVED)
			cur_byte = RTZF_RESERVED_VAL;
		else if (r.idx == RTZF_OFS_CHECKSUM)
			cur_byte = RTZF_CHK_BASE - r.sum;
	end

	// Buffer handshake terms; only full buffer stalls the framer
	assign buf_ready = (r.cnt != 2'd2);
	assign push = (r.state == RTZF_SEND) && buf_ready;
	assign pop = (r.cnt != 2'd0) && TX_READY;

	// Next-state logic for framer, buffer and option decode
	always_comb
	begin
		next_r = r;
		// Transmit option decode from host frames
		if (TX_REQ)
		begin
			next_r.status_wanted = (TX_FRAME_ID != RTZF_ZERO_BYTE);
			next_r.hops = (TX_RADIUS == RTZF_ZERO_BYTE) ? RTZF_NET_MAX_HOPS : TX_RADIUS;
		end
		// Skid buffer: shift out on pop, append on push
		if (pop)
		begin
			next_r.buf_data[0] = r.buf_data[1];
			next_r.cnt = r.cnt - 2'd1;
		end
		if (push)
		begin
			next_r.buf_data[next_r.cnt[0]] = cur_byte;
			next_r.cnt = next_r.cnt + 2'd1;
		end
		// Registered valid mirrors the next fill level
		next_r.out_valid = (next_r.cnt != 2'd0);
		case (r.state)
			RTZF_IDLE:
			begin
				if (IND_REQ)
				begin
					next_r.src64 = IND_SRC64;
					next_r.src16 = IND_SRC16;
					next_r.idx = 5'h00;
					next_r.sum = RTZF_ZERO_BYTE;
					next_r.busy = 1'b1;
					next_r.state = RTZF_SEND;
				end
			end
			RTZF_SEND:
			begin
				if (push)
				begin
					// Sum covers everything after the length field and before the checksum
					if (r.idx >= RTZF_OFS_TYPE && r.idx < RTZF_OFS_CHECKSUM)
						next_r.sum = 8'(r.sum + cur_byte);
					if (r.idx >= RTZF_OFS_SRC64_FIRST && r.idx <= RTZF_OFS_SRC64_LAST)
						next_r.src64 = {r.src64[55:0], RTZF_ZERO_BYTE};
					if (r.idx == RTZF_OFS_CHECKSUM)
						next_r.state = RTZF_DONE;
					else
						next_r.idx = r.idx + 5'h01;
				end
			end
			RTZF_DONE:
			begin
				// Hold busy until the last byte leaves, so requests never overlap
				if (r.cnt == 2'd0)
				begin
					next_r.busy = 1'b0;
					next_r.state = RTZF_IDLE;
				end
			end
			default:
				next_r.state = RTZF_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			r <= '0;
			r.state <= RTZF_IDLE;
			r.hops <= RTZF_NET_MAX_HOPS;
		end
		else
			r <= next_r;
	end

	// Outputs straight from flops
	assign TX_VALID = r.out_valid;
	assign TX_DATA = r.buf_data[0];
	assign IND_BUSY = r.busy;
	assign TX_STATUS_WANTED = r.status_wanted;
	assign TX_HOPS = r.hops;
endmodule
`default_nettype wire

//--- test/rtzf_route_ind_monitor.sv
// Purpose: Port checker for the route indicator block
// Assumes: Sees only rtzf_route_ind ports
// Notes: Counter tracks frame byte position
`timescale 1ns/1ps
`default_nettype none
module rtzf_route_ind_monitor
	import rtzf_pkg::*;
(
	// Inputs
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic IND_REQ,
	input wire logic [63:0] IND_SRC64,
	input wire logic [15:0] IND_SRC16,
	input wire logic TX_REQ,
	input wire logic [7:0] TX_FRAME_ID,
	input wire logic [7:0] TX_RADIUS,
	input wire logic TX_READY,
	// Outputs
	input wire logic IND_BUSY,
	input wire logic TX_STATUS_WANTED,
	input wire logic [7:0] TX_HOPS,
	input wire logic TX_VALID,
	input wire logic [7:0] TX_DATA
);
	logic [3:0] pos;
	logic [7:0] sum;
	wire logic acc = TX_VALID && TX_READY;
	// Position and running sum; sum restarts before the type byte
	always_ff @(posedge CLK)
	begin
		pos <= SYS_RST ? 4'h0 : pos + {3'h0, acc};
		if (acc)
			sum <= (pos < 4'h3) ? 8'h00 : sum + TX_DATA;
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	property p_start; $rose(IND_BUSY) |=> TX_VALID && TX_DATA == 8'h7E; endproperty
	a_start: assert property (p_start) else $error("no start byte");
	property p_len; acc && pos == 4'h2 |-> TX_DATA == 8'h0C; endproperty
	a_len: assert property (p_len) else $error("bad length");
	property p_type; acc && pos == 4'h3 |-> TX_DATA == 8'hA3; endproperty
	a_type: assert property (p_type) else $error("bad type");
	property p_rsvd; acc && pos == 4'hE |-> TX_DATA == 8'h00; endproperty
	a_rsvd: assert property (p_rsvd) else $error("bad reserved");
	property p_chk; acc && pos == 4'hF |-> TX_DATA == 8'hFF - sum; endproperty
	a_chk: assert property (p_chk) else $error("bad checksum");
	property p_hold; TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA); endproperty
	a_hold: assert property (p_hold) else $error("byte lost");
	property p_stat; TX_REQ |=> TX_STATUS_WANTED == ($past(TX_FRAME_ID) != 8'h00); endproperty
	a_stat: assert property (p_stat) else $error("bad status flag");
	property p_hops; TX_REQ |=> TX_HOPS == (($past(TX_RADIUS) == 8'h00) ? 8'h1E : $past(TX_RADIUS)); endproperty
	a_hops: assert property (p_hops) else $error("bad hops");
endmodule
bind rtzf_route_ind rtzf_route_ind_monitor u_mon (.*);
`default_nettype wire

//--- test/rtzf_host_model.sv
// Purpose: Host receiver on the serial byte stream
// Assumes: Byte taken on an edge with valid and ready high
// Notes: Slow mode stalls every other cycle
`timescale 1ns/1ps
`default_nettype none
module rtzf_host_model
(
	// Clock, reset, pace
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	// Byte stream
	input wire logic valid,
	input wire logic [7:0] data,
	output logic ready
);
	logic [7:0] got [0:63];
	int n;
	logic ph = 1'b0;
	// Host keeps explicit receive output enabled for management replies
	logic explicit_rx_output_option = 1'b1;
	// Explicit management frame built by the host; id and radius reach the block
	logic [7:0] cmd [0:29];
	task automatic build_cmd(input logic [7:0] id, input logic [7:0] r, input logic [15:0] nwk);
		logic [7:0] s;
		cmd[0] = 8'h7E;
		cmd[1] = 8'h00;
		cmd[2] = 8'h17;
		cmd[3] = 8'h11;
		cmd[4] = id;
		for (int i = 5; i < 11; i++)
			cmd[i] = 8'h00;
		cmd[11] = 8'hFF;
		cmd[12] = 8'hFF;
		cmd[13] = 8'hFF;
		cmd[14] = 8'hFE;
		cmd[15] = 8'h00;
		cmd[16] = 8'h00;
		cmd[17] = 8'h00;
		cmd[18] = 8'h05;
		cmd[19] = 8'h00;
		cmd[20] = 8'h00;
		cmd[21] = r;
		cmd[22] = 8'h00;
		cmd[23] = 8'h01;
		cmd[24] = nwk[7:0];
		cmd[25] = nwk[15:8];
		s = 8'h00;
		for (int i = 3; i < 26; i++)
			s += cmd[i];
		cmd[26] = 8'hFF - s;
	endtask
	assign ready = !slow || ph;
	// Keep accepted bytes in arrival order
	always_ff @(posedge clk)
	begin
		ph <= !ph;
		n <= rst ? 0 : n + int'(valid && ready);
		if (valid && ready)
			got[n] <= data;
	end
endmodule
`default_nettype wire

//--- test/route_indicator_and_zdo_frame_test.sv
// Purpose: Self-checking bench for the route indicator block
// Assumes: Host model collects output bytes
// Notes: Second request mid-frame must be dropped
`timescale 1ns/1ps
`default_nettype none
module route_indicator_and_zdo_frame_test;
	int err_count = 0;
	int num_checks = 0;
	int base;
	logic clk = 1'b0, rst = 1'b1, ind_req = 1'b0, tx_req = 1'b0, slow = 1'b0, busy, valid, ready, want;
	logic [63:0] a64 = 64'h0;
	logic [15:0] a16 = 16'h0;
	logic [7:0] fid = 8'h0, rad = 8'h0, data, hops;
	rtzf_route_ind u_dut (.CLK(clk), .SYS_RST(rst), .IND_REQ(ind_req), .IND_SRC64(a64), .IND_SRC16(a16),
		.IND_BUSY(busy), .TX_REQ(tx_req), .TX_FRAME_ID(fid), .TX_RADIUS(rad), .TX_STATUS_WANTED(want),
		.TX_HOPS(hops), .TX_VALID(valid), .TX_DATA(data), .TX_READY(ready));
	rtzf_host_model u_host (.clk(clk), .rst(rst), .slow(slow), .valid(valid), .data(data), .ready(ready));
	initial forever #2 clk = ~clk;
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Frame with a refused request inside it
	task automatic ind(input logic [63:0] s64, input logic [15:0] s16, input logic s);
		logic [119:0] f;
		logic [7:0] sum;
		@(posedge clk);
		base = u_host.n;
		{slow, a64, a16, ind_req} <= {s, s64, s16, 1'b1};
		@(posedge clk);
		ind_req <= 1'b0;
		repeat (4) @(posedge clk);
		{a64, ind_req} <= {~s64, 1'b1};
		@(posedge clk);
		ind_req <= 1'b0;
		for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clk);
		repeat (8) @(posedge clk);
		f = {32'h7E00_0CA3, s64, s16, 8'h00};
		sum = 8'h00;
		for (int i = 0; i < 15; i++)
		begin
			check(u_host.got[base + i], f[119 - 8 * i -: 8]);
			sum += (i > 2) ? f[119 - 8 * i -: 8] : 8'h00;
		end
		check(u_host.got[base + 15], 8'hFF - sum);
		check(u_host.n - base, 16);
	endtask
	// Host frame options, one-cycle requests with an idle cycle between them
	task automatic opts(input logic [7:0] id, input logic [7:0] r);
		u_host.build_cmd(id, r, 16'h1234);
		@(posedge clk);
		{tx_req, fid, rad} <= {1'b1, u_host.cmd[4], u_host.cmd[21]};
		@(posedge clk);
		tx_req <= 1'b0;
		#1 check(want, id != 8'h00);
		check(hops, (r == 8'h00) ? 8'h1E : r);
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1 check(hops, 8'h1E);
		check(want, 1'b0);
		check(busy, 1'b0);
		check(valid, 1'b0);
		ind(64'h0013_A200_4040_1122, 16'h0000, 1'b0);
		ind(64'hFEDC_BA98_7654_3210, 16'hA5C3, 1'b1);
		opts(8'h00, 8'h00);
		opts(8'h01, 8'h00);
		check(u_host.cmd[26], 8'hA6);
		opts(8'h00, 8'h07);
		opts(8'hFF, 8'hFF);
		report_and_stop;
	end
	// Hang guard
	initial
	begin
		#40000;
		err_count++;
		report_and_stop;
	end
endmodule
`default_nettype wire
